// File: common/pscr_pkg.sv
package pscr_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] PSCR_PASSWORD_OFS = 8'h10;
   localparam logic [7:0] PSCR_PIN_LIMIT_OFS = 8'h14;
   localparam logic [7:0] PSCR_PF_DCHG_OFS  = 8'h15;
   localparam logic [7:0] PSCR_BUCK_ONE_OFS = 8'h16;
   localparam logic [7:0] PSCR_GO_OFS       = 8'h1a;
   // reset values and writable-bit masks
   localparam logic [7:0] PSCR_PIN_LIMIT_RST = 8'h40;
   localparam logic [7:0] PSCR_PF_DCHG_RST  = 8'h00;
   localparam logic [7:0] PSCR_BUCK_ONE_RST = 8'h99;
   localparam logic [7:0] PSCR_PIN_LIMIT_MSK = 8'hcf;
   localparam logic [7:0] PSCR_PF_DCHG_MSK  = 8'h3f;
   localparam logic [7:0] PSCR_BUCK_ONE_MSK = 8'hbf;
   localparam logic [7:0] PSCR_UNLOCK_KEY   = 8'h7d;
   // field positions
   localparam int PSCR_PIN_SEL_BIT  = 7;
   localparam int PSCR_HYST_BIT     = 6;
   localparam int PSCR_SW3_LIM_LSB  = 2;
   localparam int PSCR_SW2_LIM_LSB  = 0;
   localparam int PSCR_PFO_LSB      = 3;
   localparam int PSCR_DCHG_LSB     = 0;
   localparam int PSCR_PFM_BIT      = 7;
   localparam int PSCR_CODE_LSB     = 0;
   localparam int PSCR_GO_BIT       = 7;
   localparam int PSCR_GO_WITH_DISCHARGE_DISABLED_BIT   = 6;
   // voltage code mapping
   localparam logic [5:0]  PSCR_CODE_KNEE   = 6'h33;
   localparam logic [10:0] PSCR_MV_BASE     = 11'd850;
   localparam logic [10:0] PSCR_MV_STEP     = 11'd10;
   localparam logic [10:0] PSCR_MV_KNEE     = 11'd1375;
   localparam logic [10:0] PSCR_MV_STEP_HI  = 11'd25;
   // blanking time after a buck register write
   localparam int PSCR_BLANK_TIME_US = 5000;
   localparam int PSCR_CLK_MHZ       = 20;
   localparam int PSCR_BLANK_CYCLES  = PSCR_BLANK_TIME_US * PSCR_CLK_MHZ;

   // one access on the internal register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] data;
   } pscr_req_t;

   // current limit in mA for a 2-bit limit field
   function automatic logic [9:0] pscr_limit_ma(input logic [1:0] sel);
      unique case (sel)
         2'h0: pscr_limit_ma = 10'd100;
         2'h1: pscr_limit_ma = 10'd200;
         2'h2: pscr_limit_ma = 10'd500;
         2'h3: pscr_limit_ma = 10'd1000;
      endcase
   endfunction

   // target voltage in mV for a 6-bit buck code
   function automatic logic [10:0] pscr_code_mv(input logic [5:0] code);
      logic [10:0] c;
      c = {5'h00, code};
      if (code < PSCR_CODE_KNEE)
         pscr_code_mv = PSCR_MV_BASE + 11'(PSCR_MV_STEP * c);
      else
         pscr_code_mv = PSCR_MV_KNEE + 11'(PSCR_MV_STEP_HI * (c - {5'h00, PSCR_CODE_KNEE}));
   endfunction
endpackage

// File: logic/pscr_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - select bit 7 set makes pin three a warm-reset input for bucks one and two.
// - while pin three is a reset input, its output-level bit is ignored.
// - bits 3-2 pick switch three limit 100/200/500/1000 mA, reset 00b.
// - bits 1-0 pick switch two limit 100/200/500/1000 mA, reset 00b.
// - power-fail bits 5,4,3 switch loads off while the power-fail input is low.
// - discharge bits 2,1,0 discharge a switch output while it is off; reset 0.
// - writes to these registers are rejected unless a valid unlock came first.
// - each buck one write blanks its over/undervoltage results for 5 ms.
// - a new buck one code takes effect only on a go or go-without-discharge write.
// - bit 7 of buck one register enables pulse-skip, 0 forces PWM; resets to 1.
// - code 0h is 0.850 V, 10 mV steps to 32h at 1.350 V, then 25 mV steps from 33h at 1.375 V; resets to 19h.
module pscr_regs
   import pscr_pkg::*;
#(
   parameter int BLANK_CYCLES = PSCR_BLANK_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire pscr_req_t  req,
   output logic      [7:0] rdata,
   input  wire logic       pin_three_level,
   input  wire logic       shared_pin_three_i,
   output logic            shared_pin_three_o,
   output logic            shared_pin_three_oe_n,
   output logic            buck_warm_reset,
   output logic            lockout_hysteresis_sel,
   output logic      [9:0] switch_three_limit_ma,
   output logic      [9:0] switch_two_limit_ma,
   input  wire logic [2:0] switch_enable,
   input  wire logic       power_fail_indication_n,
   output logic      [2:0] switch_on,
   output logic      [2:0] switch_discharge,
   input  wire logic       buck_one_ov,
   input  wire logic       buck_one_uv,
   output logic            buck_one_fault,
   output logic            buck_one_blank,
   output logic            buck_one_pulse_skip,
   output logic      [5:0] buck_one_active_code,
   output logic     [10:0] buck_one_target_mv
);
   localparam int CW = $clog2(BLANK_CYCLES + 1);

   // the blanking check below watches eight cycles, so shorter spans are refused
   if (BLANK_CYCLES < 8) begin : g_blank_check
      $error("BLANK_CYCLES must be at least eight");
   end

   // stored register bits; reserved positions are never kept
   logic [7:0] pin_limit;
   logic [7:0] pf_dchg;
   logic [7:0] buck_one;
   logic       unlocked;
   logic [CW-1:0] blank_cnt;
   // two-stage synchronisers: pin three, power fail, ov, uv
   logic [3:0] sync1;
   logic [3:0] sync2;

   // address decode; the strobes qualify it where it is used
   wire logic hit_pin   = req.addr == PSCR_PIN_LIMIT_OFS;
   wire logic hit_pf    = req.addr == PSCR_PF_DCHG_OFS;
   wire logic hit_buck  = req.addr == PSCR_BUCK_ONE_OFS;
   wire logic protected_hit = hit_pin | hit_pf | hit_buck;
   wire logic key_write = req.wr && req.addr == PSCR_PASSWORD_OFS && req.data == PSCR_UNLOCK_KEY;
   wire logic accept    = req.wr && protected_hit && unlocked;
   wire logic go_write  = req.wr && req.addr == PSCR_GO_OFS
                          && (req.data[PSCR_GO_BIT] || req.data[PSCR_GO_WITH_DISCHARGE_DISABLED_BIT]);
   wire logic pin_sel   = pin_limit[PSCR_PIN_SEL_BIT];
   wire logic pin_s     = sync2[0];
   wire logic pf_n_s    = sync2[1];
   wire logic ov_s      = sync2[2];
   wire logic uv_s      = sync2[3];

   // read mux; reserved bits are zero because they are never stored
   wire logic [7:0] read_mux = hit_pin  ? pin_limit :
                               hit_pf   ? pf_dchg :
                               hit_buck ? buck_one : 8'h00;

   // loads switched off by power fail, discharge while off
   wire logic [2:0] pfo_bits  = pf_dchg[PSCR_PFO_LSB +: 3];
   wire logic [2:0] dchg_bits = pf_dchg[PSCR_DCHG_LSB +: 3];
   wire logic [2:0] next_switch_on = switch_enable & ~(pfo_bits & {3{~pf_n_s}});
   wire logic [2:0] next_discharge = dchg_bits & ~next_switch_on;

   // monitors and pin are asynchronous to ref_clk
   // synchronisers: first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      sync1 <= {buck_one_uv, buck_one_ov, power_fail_indication_n, shared_pin_three_i};
      sync2 <= sync1;
   end

   // register storage; only writable bits are kept
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_limit <= PSCR_PIN_LIMIT_RST;
         pf_dchg   <= PSCR_PF_DCHG_RST;
         buck_one  <= PSCR_BUCK_ONE_RST;
      end else if (accept) begin
         if (hit_pin)
            pin_limit <= req.data & PSCR_PIN_LIMIT_MSK;
         if (hit_pf)
            pf_dchg <= req.data & PSCR_PF_DCHG_MSK;
         if (hit_buck)
            buck_one <= req.data & PSCR_BUCK_ONE_MSK;
      end
   end

   // unlock arms exactly one following write; any other write disarms
   // reads in between leave the key armed
   always_ff @(posedge ref_clk) begin
      if (rst)
         unlocked <= 1'b0;
      else if (req.wr)
         unlocked <= key_write;
   end

   // voltage code moves only on go; a same-cycle buck write is seen on the next go
   // the converter keeps its old code until software commits the new one
   always_ff @(posedge ref_clk) begin
      if (rst)
         buck_one_active_code <= PSCR_BUCK_ONE_RST[PSCR_CODE_LSB +: 6];
      else if (go_write)
         buck_one_active_code <= buck_one[PSCR_CODE_LSB +: 6];
   end

   // blanking timer restarted by every accepted buck one write
   always_ff @(posedge ref_clk) begin
      if (rst)
         blank_cnt <= '0;
      else if (accept && hit_buck)
         blank_cnt <= CW'(BLANK_CYCLES);
      else if (blank_cnt != '0)
         blank_cnt <= blank_cnt - 1'b1;
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata            <= 8'h00;
         switch_on        <= 3'h0;
         switch_discharge <= 3'h0;
         buck_one_fault   <= 1'b0;
         buck_warm_reset  <= 1'b0;
      end else begin
         rdata            <= req.rd ? read_mux : 8'h00;
         switch_on        <= next_switch_on;
         switch_discharge <= next_discharge;
         buck_one_fault   <= (ov_s | uv_s) & (blank_cnt == '0);
         buck_warm_reset  <= pin_sel & pin_s;
      end
   end

   // pin three: open drain, low when level bit is 0, released as a reset input
   assign shared_pin_three_o    = 1'b0;
   assign shared_pin_three_oe_n = pin_sel | pin_three_level;
   assign lockout_hysteresis_sel = pin_limit[PSCR_HYST_BIT];
   assign switch_three_limit_ma = pscr_limit_ma(pin_limit[PSCR_SW3_LIM_LSB +: 2]);
   assign switch_two_limit_ma   = pscr_limit_ma(pin_limit[PSCR_SW2_LIM_LSB +: 2]);
   assign buck_one_blank        = blank_cnt != '0;
   assign buck_one_pulse_skip   = buck_one[PSCR_PFM_BIT];
   assign buck_one_target_mv    = pscr_code_mv(buck_one_active_code);

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_locked_write;
      req.wr && protected_hit && !unlocked;
   endsequence
   sequence s_buck_write;
      accept && hit_buck;
   endsequence
   sequence s_blank_last;
      blank_cnt == CW'(1) && !(accept && hit_buck);
   endsequence

   // register port and lock
   locked_write_rejected_a: assert property (s_locked_write |=>
      $stable(pin_limit) && $stable(pf_dchg) && $stable(buck_one))
      else $error("write without unlock taken");
   unlocked_write_taken_a: assert property (accept && hit_pf |=>
      pf_dchg == (($past(req.data)) & PSCR_PF_DCHG_MSK))
      else $error("unlocked write lost");
   unlock_once_a: assert property (req.wr && !key_write |=> !unlocked)
      else $error("unlock outlived a write");
   reserved_zero_a: assert property (pin_limit[5:4] == 2'h0
      && pf_dchg[7:6] == 2'h0 && !buck_one[6])
      else $error("reserved bit set");

   // switches and pin three
   powerfail_off_a: assert property (pfo_bits[0] && !pf_n_s |=>
      !switch_on[0])
      else $error("switch one left on in power fail");
   powerfail_keep_a: assert property (!pfo_bits[1] && switch_enable[1] |=>
      switch_on[1])
      else $error("switch two dropped without its bit");
   discharge_off_a: assert property (switch_discharge[1] |-> !switch_on[1])
      else $error("discharge while switch on");
   discharge_on_a: assert property (dchg_bits[2] && !switch_enable[2] |=>
      switch_discharge[2])
      else $error("switch three not discharged while off");
   pin_released_a: assert property (pin_sel |-> shared_pin_three_oe_n)
      else $error("pin driven in reset role");
   warm_follows_a: assert property (!pin_sel |=> !buck_warm_reset)
      else $error("warm reset in output role");
   limit_decode_a: assert property (pin_limit[3:2] == 2'h3 |->
      switch_three_limit_ma == 10'd1000)
      else $error("switch three limit wrong");
   limit_two_a: assert property (pin_limit[1:0] == 2'h2 |->
      switch_two_limit_ma == 10'd500)
      else $error("switch two limit wrong");

   // buck one: code commit, blanking, mode and voltage map
   code_needs_go_a: assert property (!go_write |=> $stable(buck_one_active_code))
      else $error("code changed without go");
   go_applies_code_a: assert property (go_write |=>
      buck_one_active_code == $past(buck_one[5:0]))
      else $error("go did not apply code");
   blank_after_write_a: assert property (s_buck_write |=> buck_one_blank [*8])
      else $error("blanking not started");
   blank_ends_a: assert property (s_blank_last |=> !buck_one_blank)
      else $error("blanking overran");
   fault_masked_a: assert property (buck_one_blank |=> !buck_one_fault)
      else $error("fault shown while blanked");
   fault_shown_a: assert property (!buck_one_blank && (ov_s || uv_s) |=>
      buck_one_fault)
      else $error("fault hidden after blanking");
   voltage_map_a: assert property (buck_one_active_code == 6'h23 |->
      buck_one_target_mv == 11'd1200)
      else $error("voltage map wrong");
   pulse_skip_a: assert property (s_buck_write |=>
      buck_one_pulse_skip == $past(req.data[PSCR_PFM_BIT]))
      else $error("mode bit not reflected");
endmodule

// File: testbench/pmic_switch_buck_config_regs_bench.sv
`timescale 1ns/10ps
module pmic_switch_buck_config_regs_bench import pscr_pkg::*;;
   logic ref_clk, rst, pin_lvl, pin_i, pf_n, ov, uv, o, oe_n, warm, hys, flt, blank, pskip;
   logic [2:0] sw_en, on, dis;
   logic [5:0] code;
   logic [7:0] rdata, v;
   logic [9:0] l3, l2;
   logic [10:0] mv;
   pscr_req_t req;
   int err_count, samples_checked;
   logic [9:0] lim [4] = '{10'h064, 10'h0c8, 10'h1f4, 10'h3e8};

   pscr_host host_u (.ref_clk(ref_clk), .req(req), .rdata(rdata));
   pscr_regs #(.BLANK_CYCLES(20)) dut_u (.ref_clk(ref_clk), .rst(rst), .req(req),
      .rdata(rdata), .pin_three_level(pin_lvl), .shared_pin_three_i(pin_i),
      .shared_pin_three_o(o), .shared_pin_three_oe_n(oe_n), .buck_warm_reset(warm),
      .lockout_hysteresis_sel(hys), .switch_three_limit_ma(l3), .switch_two_limit_ma(l2),
      .switch_enable(sw_en), .power_fail_indication_n(pf_n), .switch_on(on),
      .switch_discharge(dis), .buck_one_ov(ov), .buck_one_uv(uv), .buck_one_fault(flt),
      .buck_one_blank(blank), .buck_one_pulse_skip(pskip), .buck_one_active_code(code),
      .buck_one_target_mv(mv));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // refused write leaves the reset value in place
   task automatic t_lock;
      host_u.rd(PSCR_PF_DCHG_OFS, v);
      chk(11'(v), 11'h000);
      host_u.put(1'b1, PSCR_PF_DCHG_OFS, 8'h3f);
      host_u.rd(PSCR_PF_DCHG_OFS, v);
      chk(11'(v), 11'h000);
   endtask

   // every limit code, reserved bits 5-4 forced high on the way in
   task automatic t_limits;
      for (int i = 0; i < 4; i++) begin
         host_u.wr_prot(PSCR_PIN_LIMIT_OFS, 8'h30 | 8'(i * 5));
         host_u.rd(PSCR_PIN_LIMIT_OFS, v);
         chk(11'(v), 11'(i * 5));
         chk(11'(l3), 11'(lim[i]));
         chk(11'(l2), 11'(lim[i]));
      end
   endtask

   task automatic t_pin;
      host_u.wr_prot(PSCR_PIN_LIMIT_OFS, 8'h80);
      @(posedge ref_clk);
      pin_lvl <= 1'b0;
      pin_i <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk(11'(oe_n), 11'h001);
      chk(11'(warm), 11'h001);
      host_u.wr_prot(PSCR_PIN_LIMIT_OFS, 8'h00);
      repeat (4) @(posedge ref_clk);
      #1 chk(11'(oe_n), 11'h000);
      chk(11'(o), 11'h000);
      chk(11'(warm), 11'h000);
   endtask

   // power fail drops the flagged switches, which then discharge
   task automatic t_pf;
      host_u.wr_prot(PSCR_PF_DCHG_OFS, 8'hff);
      host_u.rd(PSCR_PF_DCHG_OFS, v);
      chk(11'(v), 11'h03f);
      @(posedge ref_clk);
      sw_en <= 3'h7;
      repeat (4) @(posedge ref_clk);
      #1 chk(11'({on, dis}), 11'h038);
      pf_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk(11'({on, dis}), 11'h007);
      host_u.wr_prot(PSCR_PF_DCHG_OFS, 8'h00);
      repeat (4) @(posedge ref_clk);
      #1 chk(11'({on, dis}), 11'h038);
   endtask

   // buck write blanks monitoring; code waits for go
   task automatic t_buck;
      chk({pskip, 4'h0, code}, 11'h419);
      chk(mv, 11'h44c);
      host_u.wr_prot(PSCR_BUCK_ONE_OFS, 8'h63);
      host_u.rd(PSCR_BUCK_ONE_OFS, v);
      chk(11'(v), 11'h023);
      chk({pskip, 4'h0, code}, 11'h019);
      @(posedge ref_clk);
      ov <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 chk(11'({blank, flt}), 11'h002);
      host_u.go(PSCR_GO_BIT);
      chk(mv, 11'h4b0);
      repeat (24) @(posedge ref_clk);
      #1 chk(11'({blank, flt}), 11'h001);
      // undervoltage alone must keep the fault up
      @(posedge ref_clk);
      ov <= 1'b0;
      uv <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk(11'({blank, flt}), 11'h001);
      host_u.wr_prot(PSCR_BUCK_ONE_OFS, 8'h3f);
      host_u.go(PSCR_GO_WITH_DISCHARGE_DISABLED_BIT);
      chk({blank, 4'h0, code}, 11'h43f);
      chk(mv, 11'h68b);
   endtask

   initial begin
      rst = 1'b1;
      {pin_lvl, pin_i, pf_n, ov, uv, sw_en} = 8'ha0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      host_u.rd(PSCR_PIN_LIMIT_OFS, v);
      chk(11'(v), 11'h040);
      chk(11'(hys), 11'h001);
      t_lock();
      t_buck();
      t_limits();
      t_pin();
      t_pf();
      close_out();
   end

   // all scenarios finish well inside this span
   initial begin
      repeat (3000) @(posedge ref_clk);
      err_count++;
      close_out();
   end
endmodule

// File: testbench/pscr_host.sv
`timescale 1ns/10ps
// host side of the register port: one strobe per access, then idle
module pscr_host
   import pscr_pkg::*;
(
   input  wire logic       ref_clk,
   output pscr_req_t       req,
   input  wire logic [7:0] rdata
);
   initial req = '0;

   // strobe held one edge, released at the sampling edge
   task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{wr: w, rd: !w, addr: a, data: d};
      @(posedge ref_clk);
      req <= '0;
   endtask

   // registered read data settles just after the sampling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      put(1'b0, a, 8'h00);
      #1 d = rdata;
   endtask

   // the unlock must be the very write before a protected one
   task automatic wr_prot(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, PSCR_PASSWORD_OFS, PSCR_UNLOCK_KEY);
      put(1'b1, a, d);
   endtask

   // a new buck code is applied only by this write
   task automatic go(input int b);
      put(1'b1, PSCR_GO_OFS, 8'(8'h01 << b));
      #1;
   endtask
endmodule
